// *** tig_defines.svh ***
// constants of the transmit interpolation and gain block
`ifndef TIG_DEFINES_SVH
`define TIG_DEFINES_SVH
`define TIG_ADDR_TX_GAIN 7'h0A
`define TIG_ADDR_GAIN_SRC 7'h0B
`define TIG_ADDR_INTERP 7'h0C
`define TIG_ADDR_ROUTING 7'h0E
`define TIG_ADDR_MIRROR 7'h10
`define TIG_ADDR_SECONDARY 7'h11
`define TIG_ADDR_OFFSET 7'h12
`define TIG_ADDR_HD_POWER 7'h13
`define TIG_RST_MIRROR 8'h44
`define TIG_RST_SECONDARY 8'h43
`define TIG_RST_ZERO 8'h00
`define TIG_RST_TX_GAIN 6'h00
`define TIG_TXG_EN_BIT 6
`define TIG_SRC_TX_BIT 6
`define TIG_ROUTE_DAC_BIT 0
`define TIG_MIRROR_EN_BIT 7
`define TIG_HD_EN_BIT 7
`define TIG_LAT_X2_HALVES 9'h02B
`define TIG_LAT_X4_HALVES 9'h030
`define TIG_LAT_X1_CYCLES 9'h001
`define TIG_GAIN_MAX 6'h27
`define TIG_AMP_STEP 6'h0C
`define TIG_AMP_TWO 6'h18
`define TIG_N_MAX 3'h4
`define TIG_G1_MAX 3'h4
`define TIG_G2_MAX 3'h6
`define TIG_G3_MAX 3'h5
`define TIG_SPI_LAST 5'h0F
`define TIG_SPI_ADDR_LAST 5'h07
`define TIG_CLK_HZ 40000000
`define TIG_MAX_IN_SPS 80000000
`define TIG_MAX_DAC_SPS 200000000
`endif

// *** tig_pkg.sv ***
// types of the transmit interpolation and gain block
package tig_pkg;
    typedef enum logic [1:0] {TIG_X4, TIG_X2, TIG_X1, TIG_XBAD} tig_factor_type;
    typedef enum logic [1:0] {TIG_PWR_OFF, TIG_PWR_ON, TIG_PWR_DRAIN} tig_pwr_type;
endpackage : tig_pkg

// *** tig_stage_if.sv ***
// carrier between the block and one half-band stage
interface tig_stage_if #(parameter int W = 12);
    logic in_valid;
    logic signed [W-1:0] in_data;
    logic out_valid;
    logic signed [W-1:0] first_data;
    logic signed [W-1:0] second_data;
    modport parent (output in_valid, output in_data,
                    input out_valid, input first_data, input second_data);
    modport stage (input in_valid, input in_data,
                   output out_valid, output first_data, output second_data);
endinterface : tig_stage_if

// *** tig_hb_stage.sv ***
// one half-band 2x interpolation stage with its delay line
module tig_hb_stage #(
    parameter int TAPS = 43,
    parameter int W = 12,
    parameter int NC = (TAPS + 1) / 4,
    parameter logic [NC*16-1:0] COEF = {16'h4000, {((NC-1)*16){1'b0}}}
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    tig_stage_if.stage sif
);
    localparam int NA = (TAPS + 1) / 2;
    localparam int CD = (TAPS - 3) / 4;
    localparam int AW = W + 21;

    function automatic logic signed [W-1:0] tig_sat(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi;
        logic signed [AW-1:0] lo;
        hi = AW'({1'b0, {(W-1){1'b1}}});
        lo = -hi - AW'(1);
        if (v > hi) begin
            tig_sat = hi[W-1:0];
        end else if (v < lo) begin
            tig_sat = lo[W-1:0];
        end else begin
            tig_sat = v[W-1:0];
        end
    endfunction : tig_sat

    ////////////////////////////////////////////////////////////////////////////////
    logic signed [W-1:0] dl_ff [NA];
    logic valid_d_ff;
    logic out_valid_ff;
    logic signed [W-1:0] first_ff;
    logic signed [W-1:0] second_ff;
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] scaled;

    // symmetric branch of the polyphase pair
    always_comb begin
        acc = '0;
        for (int i = 0; i < NC; i++) begin
            acc = acc + AW'($signed(COEF[i*16 +: 16])) * (AW'(dl_ff[i]) + AW'(dl_ff[NA-1-i]));
        end
    end
    assign scaled = acc >>> 15;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dl_ff[0] <= '0;
        end else if (sif.in_valid) begin
            dl_ff[0] <= sif.in_data;
        end
    end

    for (genvar g = 1; g < NA; g++) begin : g_line
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                dl_ff[g] <= '0;
            end else if (sif.in_valid) begin
                dl_ff[g] <= dl_ff[g-1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_d_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            first_ff <= '0;
            second_ff <= '0;
        end else begin
            valid_d_ff <= sif.in_valid;
            out_valid_ff <= valid_d_ff;
            if (valid_d_ff) begin
                first_ff <= tig_sat(scaled);
                second_ff <= dl_ff[CD];
            end
        end
    end

    assign sif.out_valid = out_valid_ff;
    assign sif.first_data = first_ff;
    assign sif.second_data = second_ff;
endmodule : tig_hb_stage

// *** tig_tx_path.sv ***
// transmit interpolation, power-down and gain settings with serial register port
`include "tig_defines.svh"
module tig_tx_path
    import tig_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic mode_i,
    input wire logic [11:0] tx_data_i,
    output logic word_strobe_o,
    input wire logic transmit_enable_pin_i,
    input wire logic [5:0] gain_word_port_i,
    input wire logic sclk_i,
    input wire logic sen_n_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    output logic [11:0] dac_data_o,
    output logic dac_update_o,
    output logic dac_power_o,
    output logic current_amplifier_power_o,
    output logic interp_power_o,
    output logic [2:0] primary_gain_o,
    output logic [6:0] secondary_gain_qtr_o,
    output logic [2:0] primary_offset_current_o,
    output logic [2:0] secondary_offset_current_o,
    output logic [3:0] dac_atten_o,
    output logic [1:0] amp_atten_o
);
    function automatic tig_factor_type tig_factor(input logic [1:0] code, input logic hd);
        case (code)
            2'h0: tig_factor = TIG_X4;
            2'h1: tig_factor = TIG_X2;
            2'h2: tig_factor = hd ? TIG_X1 : TIG_X2;
            default: tig_factor = TIG_X4;
        endcase
    endfunction : tig_factor

    function automatic logic [2:0] tig_clamp(input logic [2:0] v, input logic [2:0] lim);
        tig_clamp = (v > lim) ? lim : v;
    endfunction : tig_clamp

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, a change counts when stages two and three agree
    logic [9:0] pin_raw;
    logic [9:0] s1_ff;
    logic [9:0] s2_ff;
    logic [9:0] s3_ff;
    logic [9:0] filt_ff;
    logic [9:0] prev_ff;
    logic [9:0] nxt_filt;
    assign pin_raw = {gain_word_port_i, transmit_enable_pin_i, sdio_i, sen_n_i, sclk_i};
    assign nxt_filt = ((s2_ff ~^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & filt_ff);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_ff <= 10'h002;
            s2_ff <= 10'h002;
            s3_ff <= 10'h002;
            filt_ff <= 10'h002;
            prev_ff <= 10'h002;
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sen_act;
    logic sdi;
    logic transmit_enable_pin;
    logic [5:0] gport;
    assign sclk_rise = filt_ff[0] & ~prev_ff[0];
    assign sclk_fall = ~filt_ff[0] & prev_ff[0];
    assign sen_act = ~filt_ff[1];
    assign sdi = filt_ff[2];
    assign transmit_enable_pin = filt_ff[3];
    assign gport = filt_ff[9:4];

    ////////////////////////////////////////////////////////////////////////////////
    // serial port: read flag, 7-bit address, 8-bit data, msb first
    logic [4:0] bitcnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] rd_shift_ff;
    logic sdo_ff;
    logic sdo_oe_ff;
    logic rd_ff;
    logic [15:0] rx_word;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [5:0] txg_ff;
    logic [7:0] gsrc_ff;
    logic [7:0] interp_ff;
    logic [7:0] route_ff;
    logic [7:0] mirror_ff;
    logic [7:0] second_ff;
    logic [7:0] offset_ff;
    logic [7:0] hdp_ff;
    assign rx_word = {shift_ff[14:0], sdi};
    assign wr_en = sen_act & sclk_rise & (bitcnt_ff == `TIG_SPI_LAST) & ~rx_word[15];
    assign wr_addr = rx_word[14:8];
    assign wr_data = rx_word[7:0];
    assign rd_data = (rx_word[6:0] == `TIG_ADDR_TX_GAIN) ? {2'h0, txg_ff} :
                     (rx_word[6:0] == `TIG_ADDR_GAIN_SRC) ? gsrc_ff :
                     (rx_word[6:0] == `TIG_ADDR_INTERP) ? interp_ff :
                     (rx_word[6:0] == `TIG_ADDR_ROUTING) ? route_ff :
                     (rx_word[6:0] == `TIG_ADDR_MIRROR) ? mirror_ff :
                     (rx_word[6:0] == `TIG_ADDR_SECONDARY) ? second_ff :
                     (rx_word[6:0] == `TIG_ADDR_OFFSET) ? offset_ff :
                     (rx_word[6:0] == `TIG_ADDR_HD_POWER) ? hdp_ff : `TIG_RST_ZERO;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bitcnt_ff <= '0;
            shift_ff <= '0;
            rd_shift_ff <= '0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (!sen_act) begin
            bitcnt_ff <= '0;
            sdo_oe_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (sclk_rise) begin
            shift_ff <= rx_word;
            bitcnt_ff <= bitcnt_ff + 5'h01;
            if (bitcnt_ff == `TIG_SPI_ADDR_LAST && rx_word[7]) begin
                rd_shift_ff <= rd_data;
                rd_ff <= 1'b1;
            end
        end else if (sclk_fall && rd_ff && bitcnt_ff > `TIG_SPI_ADDR_LAST) begin
            sdo_ff <= rd_shift_ff[7];
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            sdo_oe_ff <= (bitcnt_ff <= `TIG_SPI_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic wr_txg;
    assign wr_txg = wr_en & (wr_addr == `TIG_ADDR_TX_GAIN) & wr_data[`TIG_TXG_EN_BIT];
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            txg_ff <= `TIG_RST_TX_GAIN;
        end else if (wr_txg) begin
            txg_ff <= wr_data[5:0];
        end else if (gsrc_ff[`TIG_SRC_TX_BIT]) begin
            txg_ff <= gport;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gsrc_ff <= `TIG_RST_ZERO;
            interp_ff <= `TIG_RST_ZERO;
            route_ff <= `TIG_RST_ZERO;
            mirror_ff <= `TIG_RST_MIRROR;
            second_ff <= `TIG_RST_SECONDARY;
            offset_ff <= `TIG_RST_ZERO;
            hdp_ff <= `TIG_RST_ZERO;
        end else if (wr_en) begin
            case (wr_addr)
                `TIG_ADDR_GAIN_SRC: gsrc_ff <= wr_data;
                `TIG_ADDR_INTERP: interp_ff <= wr_data;
                `TIG_ADDR_ROUTING: route_ff <= wr_data;
                `TIG_ADDR_MIRROR: mirror_ff <= wr_data[`TIG_MIRROR_EN_BIT] ? wr_data : mirror_ff;
                `TIG_ADDR_SECONDARY: second_ff <= wr_data;
                `TIG_ADDR_OFFSET: offset_ff <= wr_data;
                `TIG_ADDR_HD_POWER: hdp_ff <= wr_data;
                default: hdp_ff <= hdp_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gain decode
    logic [7:0] mir_eff;
    logic [7:0] sec_eff;
    logic [2:0] g1;
    logic [2:0] g2;
    logic [2:0] g3;
    logic [6:0] nxt_sec_gain;
    logic [5:0] att;
    logic [1:0] nxt_amp_att;
    logic [5:0] dac_rem;
    logic [3:0] nxt_dac_att;
    assign mir_eff = mirror_ff[`TIG_MIRROR_EN_BIT] ? mirror_ff : `TIG_RST_MIRROR;
    assign sec_eff = mirror_ff[`TIG_MIRROR_EN_BIT] ? second_ff : `TIG_RST_SECONDARY;
    assign g1 = tig_clamp(mir_eff[6:4], `TIG_G1_MAX);
    assign g2 = tig_clamp(sec_eff[6:4], `TIG_G2_MAX);
    assign g3 = tig_clamp(sec_eff[2:0], `TIG_G3_MAX);
    assign nxt_sec_gain = 7'(g1) * 7'(g2) * 7'(g3);
    assign att = (txg_ff > `TIG_GAIN_MAX) ? `TIG_GAIN_MAX : txg_ff;
    assign nxt_amp_att = (att >= `TIG_AMP_TWO) ? 2'h2 : (att >= `TIG_AMP_STEP) ? 2'h1 : 2'h0;
    assign dac_rem = att - 6'(nxt_amp_att * `TIG_AMP_STEP);
    assign nxt_dac_att = route_ff[`TIG_ROUTE_DAC_BIT] ? txg_ff[3:0] : dac_rem[3:0];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            primary_gain_o <= `TIG_N_MAX;
            secondary_gain_qtr_o <= '0;
            primary_offset_current_o <= '0;
            secondary_offset_current_o <= '0;
            dac_atten_o <= '0;
            amp_atten_o <= '0;
        end else begin
            primary_gain_o <= tig_clamp(mir_eff[2:0], `TIG_N_MAX);
            secondary_gain_qtr_o <= nxt_sec_gain;
            primary_offset_current_o <= offset_ff[2:0];
            secondary_offset_current_o <= offset_ff[6:4];
            dac_atten_o <= nxt_dac_att;
            amp_atten_o <= route_ff[`TIG_ROUTE_DAC_BIT] ? 2'h0 : nxt_amp_att;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word timing and interpolation
    logic half_duplex_ff;
    logic strap_done_ff;
    tig_factor_type fac;
    logic [1:0] fmax;
    logic [1:0] wcnt_ff;
    logic tick_ff;
    logic [11:0] tx_word;
    assign fac = tig_factor(interp_ff[7:6], half_duplex_ff);
    assign fmax = (fac == TIG_X4) ? 2'h3 : (fac == TIG_X2) ? 2'h1 : 2'h0;
    assign tx_word = transmit_enable_pin ? tx_data_i : 12'h000;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_duplex_ff <= 1'b0;
            strap_done_ff <= 1'b0;
            wcnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            strap_done_ff <= 1'b1;
            half_duplex_ff <= strap_done_ff ? half_duplex_ff : ~mode_i;
            wcnt_ff <= (wcnt_ff >= fmax) ? 2'h0 : wcnt_ff + 2'h1;
            tick_ff <= (wcnt_ff == fmax);
        end
    end

    tig_stage_if s1_if ();
    tig_stage_if s2_if ();
    tig_hb_stage #(.TAPS(43)) u_stage1 (.clk_i(clk_i), .reset_n_i(reset_n_i), .sif(s1_if.stage));
    tig_hb_stage #(.TAPS(11)) u_stage2 (.clk_i(clk_i), .reset_n_i(reset_n_i), .sif(s2_if.stage));

    logic [1:0] s1_pend_ff;
    logic fin_valid;
    logic [11:0] fin_first;
    logic [11:0] fin_second;
    logic fin_pend_ff;
    assign s1_if.in_valid = tick_ff & (fac != TIG_X1);
    assign s1_if.in_data = tx_word;
    assign s2_if.in_valid = (fac == TIG_X4) & (s1_if.out_valid | s1_pend_ff[1]);
    assign s2_if.in_data = s1_if.out_valid ? s1_if.first_data : s1_if.second_data;
    assign fin_valid = (fac == TIG_X4) ? s2_if.out_valid : s1_if.out_valid;
    assign fin_first = (fac == TIG_X4) ? s2_if.first_data : s1_if.first_data;
    assign fin_second = (fac == TIG_X4) ? s2_if.second_data : s1_if.second_data;

    ////////////////////////////////////////////////////////////////////////////////
    // power sequencing
    tig_pwr_type pst_ff;
    tig_pwr_type nxt_pst;
    logic [8:0] drain_ff;
    logic [8:0] lat_cycles;
    logic powered;
    assign lat_cycles = (fac == TIG_X4) ? (`TIG_LAT_X4_HALVES << 1) :
                        (fac == TIG_X2) ? `TIG_LAT_X2_HALVES : `TIG_LAT_X1_CYCLES;
    assign powered = (pst_ff != TIG_PWR_OFF);
    always_comb begin
        nxt_pst = pst_ff;
        case (pst_ff)
            TIG_PWR_OFF: nxt_pst = (transmit_enable_pin || !half_duplex_ff) ? TIG_PWR_ON : TIG_PWR_OFF;
            TIG_PWR_ON: begin
                if (half_duplex_ff && !transmit_enable_pin) begin
                    nxt_pst = hdp_ff[`TIG_HD_EN_BIT] ? TIG_PWR_DRAIN : TIG_PWR_OFF;
                end
            end
            TIG_PWR_DRAIN: begin
                if (transmit_enable_pin || !half_duplex_ff) begin
                    nxt_pst = TIG_PWR_ON;
                end else if (drain_ff == 9'h000) begin
                    nxt_pst = TIG_PWR_OFF;
                end
            end
            default: nxt_pst = TIG_PWR_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pst_ff <= TIG_PWR_OFF;
            drain_ff <= '0;
        end else begin
            pst_ff <= nxt_pst;
            drain_ff <= (pst_ff == TIG_PWR_ON) ? 9'(lat_cycles + {3'h0, hdp_ff[5:0]}) :
                        (drain_ff == 9'h000) ? drain_ff : drain_ff - 9'h001;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_pend_ff <= '0;
            fin_pend_ff <= 1'b0;
            dac_data_o <= '0;
            dac_update_o <= 1'b0;
            dac_power_o <= 1'b0;
            current_amplifier_power_o <= 1'b0;
            interp_power_o <= 1'b0;
            word_strobe_o <= 1'b0;
        end else begin
            s1_pend_ff <= {s1_pend_ff[0], s1_if.out_valid};
            fin_pend_ff <= fin_valid;
            if (!powered) begin
                dac_data_o <= '0;
            end else if (fac == TIG_X1) begin
                dac_data_o <= tick_ff ? tx_word : dac_data_o;
            end else if (fin_valid) begin
                dac_data_o <= fin_first;
            end else if (fin_pend_ff) begin
                dac_data_o <= fin_second;
            end
            dac_update_o <= powered;
            dac_power_o <= powered;
            current_amplifier_power_o <= powered & ~route_ff[`TIG_ROUTE_DAC_BIT];
            interp_power_o <= powered & (fac != TIG_X1);
            word_strobe_o <= tick_ff;
        end
    end
    assign sdio_o = sdo_ff;
    assign sdio_oe_o = sdo_oe_ff;

    ////////////////////////////////////////////////////////////////////////////////
    a_bypass_direct: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (fac == TIG_X1 && tick_ff && powered) |=> dac_data_o == $past(tx_word))
        else $error("bypass sample not passed");
    a_word_spacing: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (word_strobe_o && $past(fac) == TIG_X2 && $past(fac, 2) == TIG_X2) |=> !word_strobe_o)
        else $error("words too close");
    a_stage_feed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s1_pend_ff[1] && fac == TIG_X4 && $past(fac, 2) == TIG_X4)
        |-> s2_if.in_valid && $past(s2_if.in_valid, 2))
        else $error("second stage not fed twice");
    a_drain_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (pst_ff == TIG_PWR_DRAIN && drain_ff == 9'h000 && !transmit_enable_pin && half_duplex_ff)
        |=> !powered ##1 !dac_power_o)
        else $error("drain did not end");
    a_route_amp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        route_ff[`TIG_ROUTE_DAC_BIT] |=> !current_amplifier_power_o)
        else $error("amplifier fed while routed off");
    a_primary_max: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        primary_gain_o <= `TIG_N_MAX)
        else $error("primary gain above four");
    a_mirror_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_en && wr_addr == `TIG_ADDR_MIRROR && !wr_data[`TIG_MIRROR_EN_BIT]) |=> $stable(mirror_ff))
        else $error("mirror written without enable");
    a_port_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (gsrc_ff[`TIG_SRC_TX_BIT] && !wr_txg) |=> txg_ff == $past(gport))
        else $error("gain port not loaded");
    a_hd_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (half_duplex_ff && pst_ff == TIG_PWR_ON && !transmit_enable_pin && !hdp_ff[`TIG_HD_EN_BIT])
        |=> pst_ff == TIG_PWR_OFF ##1 !dac_power_o && !interp_power_o)
        else $error("burst end did not power down");
endmodule : tig_tx_path

// *** tig_backend_model.sv ***
// back-end model feeding transmit samples
module tig_backend_model (
    input wire logic clk_i,
    input wire logic word_strobe_i,
    output logic [11:0] tx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial tx_data_o = 12'h000;
    // one new word per taken word only
    always @(negedge clk_i) begin
        if (word_strobe_i) begin
            tx_data_o <= tx_data_o + 12'h111;
        end
    end
endmodule : tig_backend_model

// *** tb_tig_tx_path.sv ***
// self-checking bench of the transmit path
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_tig_tx_path;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, reset_n_i, mode_i, ws, transmit_enable_pin, sclk_i, sen_n_i, sdio_i, sdio_o, oe;
    logic [11:0] txd, dd;
    logic [5:0] gw;
    logic du, dp, ap, ip;
    logic [2:0] pg, po, so;
    logic [6:0] sg;
    logic [3:0] da;
    logic [1:0] aa;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic oe_seen;
    tig_tx_path tig_tx_path_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
        .tx_data_i(txd), .word_strobe_o(ws), .transmit_enable_pin_i(transmit_enable_pin),
        .gain_word_port_i(gw), .sclk_i(sclk_i), .sen_n_i(sen_n_i), .sdio_i(sdio_i),
        .sdio_o(sdio_o), .sdio_oe_o(oe), .dac_data_o(dd), .dac_update_o(du),
        .dac_power_o(dp), .current_amplifier_power_o(ap), .interp_power_o(ip),
        .primary_gain_o(pg), .secondary_gain_qtr_o(sg), .primary_offset_current_o(po),
        .secondary_offset_current_o(so), .dac_atten_o(da), .amp_atten_o(aa));
    tig_backend_model tig_backend_model_inst (.clk_i(clk_i), .word_strobe_i(ws),
        .tx_data_o(txd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic wc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wc
    // one serial frame, slow clock phases of five cycles
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        sen_n_i = 1'b0;
        wc(5);
        for (int i = 15; i >= 0; i--) begin
            sdio_i = w[i];
            wc(5);
            if (i < 8) q[i] = sdio_o;
            if (i == 0) oe_seen = oe;
            sclk_i = 1'b1;
            wc(5);
            sclk_i = 1'b0;
        end
        wc(8);
        sen_n_i = 1'b1;
        wc(8);
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        `CHK(q, e)
        `CHK(oe_seen, 1'b1)
    endtask : rdc
    // clocks between two word strobes
    task automatic per(input int f);
        int n;
        n = 0;
        while (ws !== 1'b1 && n < 20) begin
            wc(1);
            n++;
        end
        wc(1);
        n = 1;
        while (ws !== 1'b1 && n < 20) begin
            wc(1);
            n++;
        end
        `CHK(n, f)
    endtask : per
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        reset_n_i = 1'b0;
        mode_i = 1'b1;
        transmit_enable_pin = 1'b1;
        gw = 6'h0D;
        sclk_i = 1'b0;
        sen_n_i = 1'b1;
        sdio_i = 1'b0;
        wc(10);
        reset_n_i = 1'b1;
        wc(8);
        `CHK(pg, 3'h4)
        `CHK(sg, 7'h30)
        rdc(7'h10, 8'h44);
        wr(7'h0A, 8'h59);
        `CHK({aa, da}, {2'h2, 4'h1})
        wr(7'h0A, 8'h05);
        `CHK({aa, da}, {2'h2, 4'h1})
        wr(7'h0B, 8'h40);
        `CHK({aa, da}, {2'h1, 4'h1})
        wr(7'h10, 8'h01);
        `CHK(pg, 3'h4)
        wr(7'h10, 8'h83);
        `CHK({pg, sg}, {3'h3, 7'h00})
        wr(7'h10, 8'hA4);
        `CHK(sg, 7'h18)
        wr(7'h11, 8'h65);
        `CHK(sg, 7'h3C)
        wr(7'h12, 8'h53);
        `CHK({so, po}, {3'h5, 3'h3})
        `CHK({dp, ap, du}, 3'b111)
        wr(7'h0E, 8'h01);
        `CHK({dp, ap}, 2'b10)
        wr(7'h0E, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(7'h0C, {c[1:0], 6'h00});
            per((c == 0 || c == 3) ? 4 : 2);
        end
        `CHK(ip, 1'b1)
        // second reset, strapped half-duplex
        reset_n_i = 1'b0;
        mode_i = 1'b0;
        transmit_enable_pin = 1'b0;
        wc(10);
        reset_n_i = 1'b1;
        wc(8);
        `CHK(dp, 1'b0)
        wr(7'h0C, 8'h80);
        wr(7'h13, 8'h8A);
        transmit_enable_pin = 1'b1;
        wc(8);
        `CHK({dp, ip}, 2'b10)
        per(1);
        `CHK(dd, txd)
        transmit_enable_pin = 1'b0;
        wc(10);
        `CHK(dp, 1'b1)
        wc(10);
        `CHK(dp, 1'b0)
        wr(7'h13, 8'h00);
        transmit_enable_pin = 1'b1;
        wc(8);
        transmit_enable_pin = 1'b0;
        wc(8);
        `CHK(dp, 1'b0)
        conclude();
    end
endmodule : tb_tig_tx_path
